// *** rtl/rcd_bcd_digit_pair.sv ***
// Purpose: Two-digit BCD increment with wrap to a given start value.
// Assumes: The input holds a valid BCD code no larger than the last value.
// Notes: Used for day, month and year counting.
`timescale 1ns/10ps
module rcd_bcd_digit_pair #(
  parameter int W = 8
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] last,
  input wire logic [W-1:0] first,
  output logic [W-1:0] next,
  output logic wrap
);
  logic [7:0] wide;
  logic [7:0] sum;
  always_comb
  begin
    wide = 8'h00;
    wide[W-1:0] = value;
    if (wide[3:0] == 4'h9)
    begin
      sum = {wide[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      sum = {wide[7:4], wide[3:0] + 4'h1};
    end
    wrap = (value == last);
    next = wrap ? first : sum[W-1:0];
  end
endmodule

// *** rtl/rcd_calendar_date.sv ***
// Purpose: Day, month, year and leap-phase fields of a real-time clock with paged access.
// Assumes: day_tick pulses once per day rollover from the time-of-day part.
// Notes: Fields hold no defined value after reset; software loads them first.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "rcd_defines.svh"
module rcd_calendar_date
  import rcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [`RCD_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic day_tick,
  output logic hour_format_24_q,
  output logic date_match_q
);
  rcd_page_e page_q;
  logic run_q;
  logic alarm_hit_q;
  logic [5:0] day_of_month_q;
  logic [4:0] month_value_q;
  logic [7:0] year_value_q;
  logic [1:0] leap_phase_q;
  logic hour_format_select_q;
  logic [5:0] alarm_day_q;
  logic [5:0] day_last;
  logic [5:0] day_next;
  logic [4:0] month_next;
  logic [7:0] year_next;
  logic day_wrap;
  logic month_wrap;
  logic year_wrap;
  logic advance;
  logic date_match_d;
  logic [7:0] rdata_d;

  assign advance = run_q && day_tick;

  // Month length; February depends on the leap phase.
  always_comb
  begin
    case (month_value_q)
      `RCD_MON_FEB: day_last = (leap_phase_q == `RCD_PHASE_LEAP) ? `RCD_DAY_29 : `RCD_DAY_28;
      `RCD_MON_APR, `RCD_MON_JUN, `RCD_MON_SEP, `RCD_MON_NOV: day_last = `RCD_DAY_30;
      default: day_last = `RCD_DAY_31;
    endcase
  end

  rcd_bcd_digit_pair #(.W(6)) u_day (
    .value(day_of_month_q),
    .last(day_last),
    .first(`RCD_DAY_FIRST),
    .next(day_next),
    .wrap(day_wrap)
  );

  rcd_bcd_digit_pair #(.W(5)) u_month (
    .value(month_value_q),
    .last(`RCD_MON_DEC),
    .first(`RCD_MON_JAN),
    .next(month_next),
    .wrap(month_wrap)
  );

  rcd_bcd_digit_pair #(.W(8)) u_year (
    .value(year_value_q),
    .last(`RCD_YEAR_LAST),
    .first(8'h00),
    .next(year_next),
    .wrap(year_wrap)
  );

  // Control state has defined reset; the clock stays stopped until software starts it.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      page_q <= RCD_PAGE0;
      run_q <= 1'b0;
    end
    else if (reg_wr && reg_addr == `RCD_OFS_CTRL)
    begin
      page_q <= rcd_page_e'(reg_wdata[`RCD_CTRL_PAGE]);
      run_q <= reg_wdata[`RCD_CTRL_RUN];
    end
  end

  // Calendar fields carry no reset so their contents stay undefined until loaded.
  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == `RCD_OFS_DAY)
    begin
      day_of_month_q <= reg_wdata[5:0];
    end
    else if (advance)
    begin
      day_of_month_q <= day_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == `RCD_OFS_MONTH && page_q == RCD_PAGE0)
    begin
      month_value_q <= reg_wdata[4:0];
    end
    else if (advance && day_wrap)
    begin
      month_value_q <= month_next;
    end
  end

  // The format bit is sampled by the hour counter; it is only safe to change with the clock stopped.
  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == `RCD_OFS_MONTH && page_q == RCD_PAGE1)
    begin
      hour_format_select_q <= reg_wdata[0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == `RCD_OFS_YEAR && page_q == RCD_PAGE0)
    begin
      year_value_q <= reg_wdata;
    end
    else if (advance && day_wrap && month_wrap)
    begin
      year_value_q <= year_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == `RCD_OFS_YEAR && page_q == RCD_PAGE1)
    begin
      leap_phase_q <= reg_wdata[1:0];
    end
    else if (advance && day_wrap && month_wrap)
    begin
      leap_phase_q <= leap_phase_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_wr && reg_addr == `RCD_OFS_ALARM)
    begin
      alarm_day_q <= reg_wdata[5:0];
    end
  end

  assign date_match_d = (alarm_day_q == `RCD_DAY_DONT_CARE) || (alarm_day_q == day_of_month_q);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      date_match_q <= 1'b0;
      hour_format_24_q <= 1'b0;
    end
    else
    begin
      date_match_q <= date_match_d;
      hour_format_24_q <= hour_format_select_q;
    end
  end

  // Sticky match flag; a new match in the clearing cycle wins.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_hit_q <= 1'b0;
    end
    else if (advance && date_match_d)
    begin
      alarm_hit_q <= 1'b1;
    end
    else if (reg_wr && reg_addr == `RCD_OFS_CTRL && reg_wdata[`RCD_CTRL_ALARM_HIT])
    begin
      alarm_hit_q <= 1'b0;
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      `RCD_OFS_DAY: rdata_d[5:0] = day_of_month_q;
      `RCD_OFS_MONTH:
      begin
        if (page_q == RCD_PAGE0)
        begin
          rdata_d[4:0] = month_value_q;
        end
        else
        begin
          rdata_d[0] = hour_format_select_q;
        end
      end
      `RCD_OFS_YEAR:
      begin
        if (page_q == RCD_PAGE0)
        begin
          rdata_d = year_value_q;
        end
        else
        begin
          rdata_d[1:0] = leap_phase_q;
        end
      end
      `RCD_OFS_CTRL:
      begin
        rdata_d[`RCD_CTRL_PAGE] = page_q;
        rdata_d[`RCD_CTRL_RUN] = run_q;
        rdata_d[`RCD_CTRL_ALARM_HIT] = alarm_hit_q;
      end
      `RCD_OFS_ALARM: rdata_d[5:0] = alarm_day_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// *** rtl/rcd_defines.svh ***
// Purpose: Register offsets, address width, control bit positions and codes of the calendar date block.
// Assumes: Byte-wide registers reached over a plain strobe port.
// Notes: Offsets are register indices on the local register port.
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH
`define RCD_ADDR_W 3
`define RCD_OFS_DAY 3'h0
`define RCD_OFS_MONTH 3'h1
`define RCD_OFS_YEAR 3'h2
`define RCD_OFS_CTRL 3'h3
`define RCD_OFS_ALARM 3'h4
`define RCD_CTRL_PAGE 0
`define RCD_CTRL_RUN 1
`define RCD_CTRL_ALARM_HIT 2
`define RCD_DAY_FIRST 6'h01
`define RCD_DAY_DONT_CARE 6'h3f
`define RCD_DAY_28 6'h28
`define RCD_DAY_29 6'h29
`define RCD_DAY_30 6'h30
`define RCD_DAY_31 6'h31
`define RCD_MON_JAN 5'h01
`define RCD_MON_FEB 5'h02
`define RCD_MON_APR 5'h04
`define RCD_MON_JUN 5'h06
`define RCD_MON_SEP 5'h09
`define RCD_MON_NOV 5'h11
`define RCD_MON_DEC 5'h12
`define RCD_YEAR_LAST 8'h99
`define RCD_PHASE_LEAP 2'h0
`endif

// *** rtl/rcd_pkg.sv ***
// Purpose: Types shared by the calendar date block.
// Assumes: Nothing beyond the defines header.
// Notes: Holds the register page selection.
package rcd_pkg;
  typedef enum logic {RCD_PAGE0, RCD_PAGE1} rcd_page_e;
endpackage

// *** testbench/rcd_calendar_date_assertions.sv ***
// Purpose: Port checks of the calendar date block.
// Assumes: Index 0 day, 1 month, 2 year, 3 control, 4 alarm day.
// Notes: The page bit is mirrored here because it reaches a port only through a control register read.
`timescale 1ns/10ps
module rcd_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic day_tick,
  input wire logic hour_format_24_q,
  input wire logic date_match_q
);
  logic pg_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pg_q <= 1'b0;
    else if (reg_wr && reg_addr == 3'h3)
      pg_q <= reg_wdata[0];
  end
  sequence s_yw;
    reg_wr && reg_addr == 3'h2 && !pg_q;
  endsequence
  sequence s_yr;
    reg_rd && reg_addr == 3'h2 && !pg_q && !day_tick;
  endsequence
  property p_day; reg_rd && reg_addr == 3'h0 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_day: assert property (p_day) else $error("day top bits set");
  property p_mon; reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:5] == 3'h0; endproperty
  a_mon: assert property (p_mon) else $error("month top bits set");
  property p_fhi; reg_rd && reg_addr == 3'h1 && pg_q |=> reg_rdata[7:1] == 7'h0; endproperty
  a_fhi: assert property (p_fhi) else $error("format top bits set");
  property p_fmt; reg_wr && reg_addr == 3'h1 && pg_q |=> ##1 hour_format_24_q == $past(reg_wdata[0], 2); endproperty
  a_fmt: assert property (p_fmt) else $error("format output wrong");
  property p_pg0; reg_wr && reg_addr == 3'h1 && !pg_q |=> ##1 $stable(hour_format_24_q); endproperty
  a_pg0: assert property (p_pg0) else $error("month write moved format");
  property p_lhi; reg_rd && reg_addr == 3'h2 && pg_q |=> reg_rdata[7:2] == 6'h0; endproperty
  a_lhi: assert property (p_lhi) else $error("phase top bits set");
  property p_any; reg_wr && reg_addr == 3'h4 && reg_wdata[5:0] == 6'h3f |-> ##[1:2] date_match_q; endproperty
  a_any: assert property (p_any) else $error("wildcard day no match");
  property p_yr; s_yw ##1 s_yr |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_yr: assert property (p_yr) else $error("year readback wrong");
endmodule
bind rcd_calendar_date rcd_chk chk_u (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .day_tick(day_tick),
  .hour_format_24_q(hour_format_24_q), .date_match_q(date_match_q));

// *** testbench/testbench.sv ***
// Purpose: Directed register test of the calendar date block.
// Assumes: Control bit 0 is page, bit 1 is run, bit 2 is the sticky alarm hit.
// Notes: Fixed waits follow the one-cycle read latency.
`timescale 1ns/10ps
module testbench;
  logic sys_clk, nrst, reg_wr, reg_rd, day_tick;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire hour_format_24_q, date_match_q;
  int error_cnt, samples_checked;
  rcd_calendar_date dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .day_tick(day_tick),
    .hour_format_24_q(hour_format_24_q), .date_match_q(date_match_q));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
    @(posedge sys_clk);
  endtask
  task automatic tick;
    day_tick <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    day_tick <= 1'b0;
  endtask
  task automatic alm(input logic [7:0] d, input logic e);
    wr(3'h4, d);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("match", {7'h0, e}, {7'h0, date_match_q});
    @(posedge sys_clk);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    {nrst, reg_wr, reg_rd, day_tick, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge sys_clk);
    chk("reset", 8'h0, {reg_rdata[5:0], hour_format_24_q, date_match_q});
    nrst <= 1'b1;
    @(posedge sys_clk);
    // Load the format bit and phase first so no field is unknown when the checker looks at it.
    wr(3'h3, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hf1);
    rd(3'h0, 8'h31);
    wr(3'h1, 8'hf2);
    rd(3'h1, 8'h12);
    wr(3'h2, 8'h99);
    rd(3'h2, 8'h99);
    rd(3'h7, 8'h00);
    wr(3'h3, 8'h01);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h01);
    chk("format", 8'h01, {7'h0, hour_format_24_q});
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h03);
    wr(3'h3, 8'h02);
    rd(3'h1, 8'h12);
    tick();
    rd(3'h0, 8'h01);
    rd(3'h1, 8'h01);
    rd(3'h2, 8'h00);
    wr(3'h3, 8'h03);
    rd(3'h2, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      wr(3'h3, 8'h03);
      wr(3'h2, 8'(p));
      wr(3'h3, 8'h02);
      wr(3'h0, 8'h28);
      wr(3'h1, 8'h02);
      tick();
      rd(3'h0, p ? 8'h01 : 8'h29);
    end
    alm(8'h3f, 1'b1);
    alm(8'h05, 1'b0);
    alm(8'h01, 1'b1);
    // A counted tick while the day matches sets the sticky hit; writing one to it clears it.
    tick();
    rd(3'h3, 8'h06);
    wr(3'h3, 8'h06);
    rd(3'h3, 8'h02);
    // With the clock stopped a tick must leave the day alone.
    wr(3'h3, 8'h00);
    tick();
    rd(3'h0, 8'h02);
    stop_test();
  end
endmodule
